// ### design/branch_and_operand_address_gen.sv
// Program counter and operand address generation for an 8-bit core.
// Assumes the decoder presents one step per cycle while pc_ready is high and a
// byte-wide program memory read port on the same clock that answers with rd_ack.
//
// Behaviour
// - no branch advances PC by length
// - relative target is next address plus offset
// - offset signed, bit 7 sign extended
// - short jump and conditionals use relative
// - absolute jump or call loads immediate
// - register jump copies accumulator pair
// - direct operand address is field unchanged
// - word register access only via short direct
// - short direct maps into FE20H to FF1FH
`timescale 1ns/1ps
module branch_and_operand_address_gen (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // Program counter step from the decoder
    input  wire logic        step_valid,
    input  wire logic [2:0]  step_kind,
    input  wire logic [2:0]  instr_len,
    input  wire logic [7:0]  opcode_byte,
    input  wire logic [7:0]  signed_branch_offset,
    input  wire logic [15:0] absolute_target_field,
    input  wire logic [15:0] accumulator_pair,
    // Program memory read port for vectors and table entries
    output logic             rd_req,
    output logic      [15:0] rd_addr,
    input  wire logic        rd_ack,
    input  wire logic [7:0]  rd_data,
    // Program counter results
    output logic      [15:0] pc,
    output logic             pc_ready,
    output logic      [15:0] return_addr,
    // Operand address request
    input  wire logic        opnd_valid,
    input  wire logic        opnd_kind,
    input  wire logic        opnd_word,
    input  wire logic [15:0] opnd_direct_field,
    input  wire logic [7:0]  opnd_short_field,
    // Operand address result
    output logic      [15:0] opnd_addr,
    output logic             opnd_done,
    output logic             opnd_word_ok,
    output logic             opnd_refused
);

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        addr_gen_pkg::seq_state_t st;
        logic [15:0]              pc;
        logic                     pc_ready;
        logic [15:0]              return_addr;
        logic                     rd_req;
        logic [15:0]              rd_addr;
        logic [7:0]               lo_byte;
        logic [15:0]              opnd_addr;
        logic                     opnd_done;
        logic                     opnd_word_ok;
        logic                     opnd_refused;
    } gen_state_t;

    localparam gen_state_t STATE_RESET = '{
        st:           addr_gen_pkg::ST_VEC_LO,
        pc:           addr_gen_pkg::PC_RESET,
        pc_ready:     1'b0,
        return_addr:  addr_gen_pkg::PC_RESET,
        rd_req:       1'b1,
        rd_addr:      addr_gen_pkg::RESET_VEC_ADDR,
        lo_byte:      8'h00,
        opnd_addr:    16'h0000,
        opnd_done:    1'b0,
        opnd_word_ok: 1'b0,
        opnd_refused: 1'b0
    };

    gen_state_t cur;
    gen_state_t next_cur;
    logic [15:0] next_seq;
    logic [15:0] rel_target;
    logic [15:0] table_addr;
    logic [15:0] short_addr;
    logic        step_take;

    // ------------------------------------------------------------------
    // Arithmetic
    // ------------------------------------------------------------------
    addr_arith i_addr_arith (
        .pc                   (cur.pc),
        .instr_len            (instr_len),
        .signed_branch_offset (signed_branch_offset),
        .table_index_field    (opcode_byte[5:1]),
        .short_field          (opnd_short_field),
        .next_seq             (next_seq),
        .rel_target           (rel_target),
        .table_addr           (table_addr),
        .short_addr           (short_addr)
    );

    // Steps are only taken while the sequencer is free
    assign step_take = step_valid && cur.pc_ready;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // One process covers both the branch sequencer and the operand path;
    // the operand path is independent and answers every request in one cycle.
    always_comb begin
        next_cur = cur;
        next_cur.opnd_done = 1'b0;
        case (cur.st)
            addr_gen_pkg::ST_VEC_LO: begin
                if (rd_ack) begin
                    next_cur.lo_byte = rd_data;
                    next_cur.rd_addr = cur.rd_addr + addr_gen_pkg::ADDR_ONE;
                    next_cur.st      = addr_gen_pkg::ST_VEC_HI;
                end
            end
            addr_gen_pkg::ST_TBL_LO: begin
                if (rd_ack) begin
                    next_cur.lo_byte = rd_data;
                    next_cur.rd_addr = cur.rd_addr + addr_gen_pkg::ADDR_ONE;
                    next_cur.st      = addr_gen_pkg::ST_TBL_HI;
                end
            end
            addr_gen_pkg::ST_VEC_HI,
            addr_gen_pkg::ST_TBL_HI: begin
                if (rd_ack) begin
                    next_cur.pc       = {rd_data, cur.lo_byte};
                    next_cur.rd_req   = 1'b0;
                    next_cur.pc_ready = 1'b1;
                    next_cur.st       = addr_gen_pkg::ST_RUN;
                end
            end
            addr_gen_pkg::ST_RUN: begin
                if (step_take) begin
                    next_cur.return_addr = next_seq;
                    case (step_kind)
                        addr_gen_pkg::STEP_REL: next_cur.pc = rel_target;
                        addr_gen_pkg::STEP_ABS: next_cur.pc = absolute_target_field;
                        addr_gen_pkg::STEP_REG: next_cur.pc = accumulator_pair;
                        addr_gen_pkg::STEP_TBL: begin
                            next_cur.rd_req   = 1'b1;
                            next_cur.rd_addr  = table_addr;
                            next_cur.pc_ready = 1'b0;
                            next_cur.st       = addr_gen_pkg::ST_TBL_LO;
                        end
                        default: next_cur.pc = next_seq;
                    endcase
                end
            end
            default: next_cur = STATE_RESET;
        endcase

        // Operand address formation
        if (opnd_valid) begin
            next_cur.opnd_done = 1'b1;
            if (opnd_kind == addr_gen_pkg::OPND_SHORT) begin
                next_cur.opnd_addr    = short_addr;
                next_cur.opnd_word_ok = opnd_word;
                next_cur.opnd_refused = 1'b0;
            end else begin
                next_cur.opnd_addr = opnd_direct_field;
                next_cur.opnd_refused = opnd_word &&
                    (opnd_direct_field[15:8] == addr_gen_pkg::SFR_PAGE);
                next_cur.opnd_word_ok = opnd_word &&
                    (opnd_direct_field[15:8] != addr_gen_pkg::SFR_PAGE);
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cur <= STATE_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs straight from the state record
    assign pc           = cur.pc;
    assign pc_ready     = cur.pc_ready;
    assign return_addr  = cur.return_addr;
    assign rd_req       = cur.rd_req;
    assign rd_addr      = cur.rd_addr;
    assign opnd_addr    = cur.opnd_addr;
    assign opnd_done    = cur.opnd_done;
    assign opnd_word_ok = cur.opnd_word_ok;
    assign opnd_refused = cur.opnd_refused;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_step(logic [2:0] k);
        step_valid && pc_ready && step_kind == k;
    endsequence

    sequence s_tbl_lo_done;
        cur.st == addr_gen_pkg::ST_TBL_LO && rd_ack;
    endsequence

    property p_seq_step;
        @(posedge sys_clk) disable iff (!resetn)
        s_step(addr_gen_pkg::STEP_SEQ) |=> pc == $past(pc) + {13'h0000, $past(instr_len)};
    endproperty
    a_seq_step: assert property (p_seq_step) else $error("sequential step wrong");

    property p_rel_sum;
        @(posedge sys_clk) disable iff (!resetn)
        s_step(addr_gen_pkg::STEP_REL) |=> pc == $past(pc) + {13'h0000, $past(instr_len)} +
            {{8{$past(signed_branch_offset[7])}}, $past(signed_branch_offset)};
    endproperty
    a_rel_sum: assert property (p_rel_sum) else $error("relative target wrong");

    property p_rel_back;
        @(posedge sys_clk) disable iff (!resetn)
        s_step(addr_gen_pkg::STEP_REL) ##0 signed_branch_offset[7] |=> pc < return_addr
            || return_addr < 16'h0080;
    endproperty
    a_rel_back: assert property (p_rel_back) else $error("negative offset not backward");

    property p_rel_ready;
        @(posedge sys_clk) disable iff (!resetn)
        s_step(addr_gen_pkg::STEP_REL) |=> pc_ready && !rd_req;
    endproperty
    a_rel_ready: assert property (p_rel_ready) else $error("relative branch stalled");

    property p_abs_load;
        @(posedge sys_clk) disable iff (!resetn)
        s_step(addr_gen_pkg::STEP_ABS) |=> pc == $past(absolute_target_field);
    endproperty
    a_abs_load: assert property (p_abs_load) else $error("absolute target wrong");

    property p_tbl_start;
        @(posedge sys_clk) disable iff (!resetn)
        s_step(addr_gen_pkg::STEP_TBL) |=> rd_req && !pc_ready &&
            rd_addr == addr_gen_pkg::TABLE_BASE + {10'h000, $past(opcode_byte[5:1]), 1'b0};
    endproperty
    a_tbl_start: assert property (p_tbl_start) else $error("table entry address wrong");

    property p_tbl_pair;
        @(posedge sys_clk) disable iff (!resetn)
        s_tbl_lo_done |=> rd_addr == $past(rd_addr) + addr_gen_pkg::ADDR_ONE
            && rd_addr[0] == 1'b1;
    endproperty
    a_tbl_pair: assert property (p_tbl_pair) else $error("table high byte address wrong");

    property p_reg_load;
        @(posedge sys_clk) disable iff (!resetn)
        s_step(addr_gen_pkg::STEP_REG) |=> pc == $past(accumulator_pair);
    endproperty
    a_reg_load: assert property (p_reg_load) else $error("register jump wrong");

    property p_direct;
        @(posedge sys_clk) disable iff (!resetn)
        opnd_valid && opnd_kind == addr_gen_pkg::OPND_DIRECT |=>
            opnd_done && opnd_addr == $past(opnd_direct_field);
    endproperty
    a_direct: assert property (p_direct) else $error("direct operand address wrong");

    property p_word_gate;
        @(posedge sys_clk) disable iff (!resetn)
        opnd_done && opnd_addr[15:8] == addr_gen_pkg::SFR_PAGE && opnd_word_ok |->
            $past(opnd_kind) == addr_gen_pkg::OPND_SHORT;
    endproperty
    a_word_gate: assert property (p_word_gate) else $error("word register access leaked");

    property p_short_map;
        @(posedge sys_clk) disable iff (!resetn)
        opnd_valid && opnd_kind == addr_gen_pkg::OPND_SHORT |=>
            opnd_addr >= 16'hfe20 && opnd_addr <= 16'hff1f
            && opnd_addr[7:0] == $past(opnd_short_field);
    endproperty
    a_short_map: assert property (p_short_map) else $error("short direct address wrong");

    property p_vec_done;
        @(posedge sys_clk) disable iff (!resetn)
        cur.st == addr_gen_pkg::ST_VEC_HI && rd_ack |=>
            pc_ready && pc == {$past(rd_data), $past(cur.lo_byte)};
    endproperty
    a_vec_done: assert property (p_vec_done) else $error("reset vector not applied");

endmodule

// ### design/addr_gen_pkg.sv
// Constants and types shared by the program counter and operand address logic.
// Assumes a single 20 MHz core clock and a byte-wide program memory read port.
package addr_gen_pkg;

    // ------------------------------------------------------------------
    // Address map constants
    // ------------------------------------------------------------------
    localparam logic [15:0] RESET_VEC_ADDR  = 16'h0000; // Vector word, low byte first
    localparam logic [15:0] TABLE_BASE      = 16'h0040; // Vectored call table start
    localparam logic [15:0] PC_RESET        = 16'h0000;
    localparam logic [7:0]  SHORT_RAM_START = 8'h20;    // Field at or above: RAM page
    localparam logic [7:0]  SHORT_PAGE_RAM  = 8'hfe;    // Bit 8 clear
    localparam logic [7:0]  SHORT_PAGE_SFR  = 8'hff;    // Bit 8 set
    localparam logic [7:0]  SFR_PAGE        = 8'hff;    // Word registers live here
    localparam logic [15:0] ADDR_ONE        = 16'h0001;

    // ------------------------------------------------------------------
    // Program counter step kinds, from the instruction decoder
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        STEP_SEQ = 3'b000,  // Fall through, no branch
        STEP_REL = 3'b001,  // Short jump or any conditional branch taken
        STEP_ABS = 3'b010,  // Absolute jump or call
        STEP_TBL = 3'b011,  // Vectored table call
        STEP_REG = 3'b100   // Jump through the accumulator pair
    } step_kind_t;

    // Operand address kinds
    typedef enum logic {
        OPND_DIRECT = 1'b0,
        OPND_SHORT  = 1'b1
    } opnd_kind_t;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_VEC_LO = 3'b000,
        ST_VEC_HI = 3'b001,
        ST_RUN    = 3'b010,
        ST_TBL_LO = 3'b011,
        ST_TBL_HI = 3'b100
    } seq_state_t;

endpackage

// ### design/addr_arith.sv
// Combinational target arithmetic for the address generator.
// Assumes its inputs are registered or stable decoder fields on the core clock.
`timescale 1ns/1ps
module addr_arith (
    // Program counter side
    input  wire logic [15:0] pc,
    input  wire logic [2:0]  instr_len,
    input  wire logic [7:0]  signed_branch_offset,
    input  wire logic [4:0]  table_index_field,
    // Operand side
    input  wire logic [7:0]  short_field,
    // Results
    output logic      [15:0] next_seq,
    output logic      [15:0] rel_target,
    output logic      [15:0] table_addr,
    output logic      [15:0] short_addr
);

    // Sign extension of the displacement, bit 7 copied upward
    function automatic logic [15:0] sext8(input logic [7:0] v);
        sext8 = {{8{v[7]}}, v};
    endfunction

    // ------------------------------------------------------------------
    // Target arithmetic
    // ------------------------------------------------------------------
    // advance by length
    assign next_seq   = pc + {13'h0000, instr_len};
    assign rel_target = next_seq + sext8(signed_branch_offset);
    assign table_addr = addr_gen_pkg::TABLE_BASE + {10'h000, table_index_field, 1'b0};
    assign short_addr = (short_field >= addr_gen_pkg::SHORT_RAM_START) ?
                        {addr_gen_pkg::SHORT_PAGE_RAM, short_field} :
                        {addr_gen_pkg::SHORT_PAGE_SFR, short_field};

endmodule

// ### bench/prog_mem_model.sv
// Program memory model that answers vector and table byte reads.
// Assumes the requester holds rd_req and rd_addr until it samples rd_ack high.
`timescale 1ns/1ps
module prog_mem_model (
    // Clock
    input  wire logic        sys_clk,
    // Read port
    input  wire logic        rd_req,
    input  wire logic [15:0] rd_addr,
    output logic             rd_ack,
    output logic      [7:0]  rd_data,
    // Answer speed: three extra wait cycles when high
    input  wire logic        slow
);
    // ------------------------------------------------------------------
    // Read answer
    // ------------------------------------------------------------------
    logic [1:0] wait_cnt;

    initial begin
        rd_ack   = 1'b0;
        rd_data  = 8'h00;
        wait_cnt = 2'h0;
    end

    // One ack per request; data is scrambled outside acks so a stale byte never looks valid
    always @(posedge sys_clk) begin
        if (rd_ack || !rd_req) begin
            rd_ack   <= 1'b0;
            rd_data  <= ~rd_data;
            wait_cnt <= 2'h0;
        end else if (!slow || wait_cnt == 2'h3) begin
            rd_ack   <= 1'b1;
            rd_data  <= rd_addr[7:0] ^ rd_addr[15:8] ^ 8'h5a;
        end else begin
            wait_cnt <= wait_cnt + 2'h1;
            rd_data  <= ~rd_data;
        end
    end
endmodule

// ### bench/branch_and_operand_address_gen_tb.sv
// Self-checking bench for the program counter and operand address generator.
// Assumes a 20 MHz clock and the program memory model on the read port.
`timescale 1ns/1ps
module branch_and_operand_address_gen_tb;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        sys_clk, resetn, slow, chk_pc, ready_q;
    logic        step_valid, rd_req, rd_ack, pc_ready;
    logic [2:0]  step_kind, instr_len;
    logic [7:0]  opcode_byte, signed_branch_offset, rd_data, opnd_short_field;
    logic [15:0] absolute_target_field, accumulator_pair, rd_addr, pc, return_addr;
    logic        opnd_valid, opnd_kind, opnd_word, opnd_done, opnd_word_ok, opnd_refused;
    logic [15:0] opnd_direct_field, opnd_addr, pc_m;
    logic [31:0] seed, r1, r2;
    logic [31:0] pc_q[$];
    logic [17:0] op_q[$];
    int          num_errors, tests_run;

    branch_and_operand_address_gen i_branch_and_operand_address_gen (
        .sys_clk(sys_clk), .resetn(resetn), .step_valid(step_valid), .step_kind(step_kind),
        .instr_len(instr_len), .opcode_byte(opcode_byte),
        .signed_branch_offset(signed_branch_offset),
        .absolute_target_field(absolute_target_field), .accumulator_pair(accumulator_pair),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data),
        .pc(pc), .pc_ready(pc_ready), .return_addr(return_addr),
        .opnd_valid(opnd_valid), .opnd_kind(opnd_kind), .opnd_word(opnd_word),
        .opnd_direct_field(opnd_direct_field), .opnd_short_field(opnd_short_field),
        .opnd_addr(opnd_addr), .opnd_done(opnd_done), .opnd_word_ok(opnd_word_ok),
        .opnd_refused(opnd_refused));

    prog_mem_model i_prog_mem_model (
        .sys_clk(sys_clk), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack),
        .rd_data(rd_data), .slow(slow));

    // Clock, 50 ns period
    always #25 sys_clk = ~sys_clk;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Byte the memory model holds at an address
    function automatic logic [7:0] mem_byte(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Offer one step and hold it until an edge samples pc_ready high
    task automatic step(input logic [2:0] k, input logic [2:0] len, input logic [7:0] off,
                        input logic [15:0] tgt, input logic [4:0] idx);
        logic [15:0] nxt;
        logic [15:0] ent;
        int          n;
        step_valid            <= 1'b1;
        step_kind             <= k;
        instr_len             <= len;
        signed_branch_offset  <= off;
        absolute_target_field <= tgt;
        accumulator_pair      <= ~tgt;
        opcode_byte           <= {2'b11, idx, 1'b1};
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pc_ready !== 1'b1 && n < 200);
        if (n >= 200) num_errors++;
        ent = 16'h0040 + {10'h000, idx, 1'b0};
        case (k)
            addr_gen_pkg::STEP_REL: nxt = pc_m + {13'h0000, len} + {{8{off[7]}}, off};
            addr_gen_pkg::STEP_ABS: nxt = tgt;
            addr_gen_pkg::STEP_TBL: nxt = {mem_byte(ent + 16'h0001), mem_byte(ent)};
            addr_gen_pkg::STEP_REG: nxt = ~tgt;
            default:                nxt = pc_m + {13'h0000, len};
        endcase
        pc_q.push_back({nxt, pc_m + {13'h0000, len}});
        pc_m = nxt;
    endtask

    // Offer one operand request, taken at the next edge
    task automatic opnd(input logic k, input logic w, input logic [15:0] d, input logic [7:0] s);
        logic [15:0] a;
        logic        rf;
        opnd_valid        <= 1'b1;
        opnd_kind         <= k;
        opnd_word         <= w;
        opnd_direct_field <= d;
        opnd_short_field  <= s;
        @(posedge sys_clk);
        rf = !k && w && d[15:8] == 8'hff;
        a  = k ? {(s < 8'h20) ? 8'hff : 8'hfe, s} : d;
        op_q.push_back({a, w && !rf, rf});
    endtask

    // ------------------------------------------------------------------
    // Result watcher: oldest note is compared whenever a result shows
    // ------------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (chk_pc || (pc_ready === 1'b1 && ready_q !== 1'b1)) begin
            if (pc_q.size() != 0) check({pc, return_addr}, pc_q.pop_front());
            else check(32'h0000_0000, 32'hffff_ffff);
        end
        if (opnd_done === 1'b1) begin
            if (op_q.size() != 0) check({14'h0, opnd_addr, opnd_word_ok, opnd_refused},
                                        {14'h0, op_q.pop_front()});
            else check(32'h0000_0000, 32'hffff_ffff);
        end
        chk_pc  <= resetn && step_valid && pc_ready && step_kind != addr_gen_pkg::STEP_TBL;
        ready_q <= pc_ready;
    end

    // Watchdog, far beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        $display("Watchdog expired at t=%0t", $time);
        summarize();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0; resetn = 1'b0; slow = 1'b0; chk_pc = 1'b0; ready_q = 1'b0;
        seed = 32'd97584; num_errors = 0; tests_run = 0;
        step_valid = 1'b0; step_kind = 3'h0; instr_len = 3'h1; opcode_byte = 8'h00;
        signed_branch_offset = 8'h00; absolute_target_field = 16'h0000;
        accumulator_pair = 16'h0000; opnd_valid = 1'b0; opnd_kind = 1'b0; opnd_word = 1'b0;
        opnd_direct_field = 16'h0000; opnd_short_field = 8'h00;
        pc_m = 16'h5b5a;
        pc_q.push_back({16'h5b5a, 16'h0000});
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        fork
            begin
                step(addr_gen_pkg::STEP_REL, 3'h2, 8'h7f, 16'h0000, 5'h00);
                step(addr_gen_pkg::STEP_REL, 3'h2, 8'h80, 16'h0000, 5'h00);
                step(addr_gen_pkg::STEP_SEQ, 3'h4, 8'h80, 16'h0000, 5'h00);
                step(addr_gen_pkg::STEP_ABS, 3'h3, 8'h00, 16'hfffe, 5'h00);
                step(addr_gen_pkg::STEP_REG, 3'h1, 8'h00, 16'h1234, 5'h00);
                // Every table entry, memory answering fast and slow by turns
                for (int i = 0; i < 32; i++) begin
                    slow <= i[0];
                    step(addr_gen_pkg::STEP_TBL, 3'h1, 8'h00, 16'h0000, i[4:0]);
                end
                // Random kinds back to back, unknown codes included
                for (int i = 0; i < 80; i++) begin
                    r1 = xs();
                    step(r1[2:0], 3'h1 + {1'b0, r1[4:3]}, r1[15:8], r1[31:16], r1[9:5]);
                end
                step_valid <= 1'b0;
            end
            begin
                opnd(1'b1, 1'b1, 16'h0000, 8'h00);
                opnd(1'b1, 1'b1, 16'h0000, 8'h1f);
                opnd(1'b1, 1'b0, 16'h0000, 8'h20);
                opnd(1'b1, 1'b1, 16'h0000, 8'hff);
                opnd(1'b0, 1'b1, 16'hff12, 8'h00);
                opnd(1'b0, 1'b1, 16'hfe20, 8'h00);
                opnd(1'b0, 1'b0, 16'hff12, 8'h00);
                for (int i = 0; i < 80; i++) begin
                    r2 = xs();
                    opnd(r2[0], r2[1], r2[2] ? {8'hff, r2[15:8]} : r2[31:16], r2[23:16]);
                end
                opnd_valid <= 1'b0;
            end
        join
        // Let a table call still in flight finish, so its note is used up
        do @(posedge sys_clk); while (pc_ready !== 1'b1);
        repeat (5) @(posedge sys_clk);
        // Reset in mid-run must reload the vector
        resetn <= 1'b0;
        pc_q.push_back({16'h5b5a, 16'h0000});
        pc_m = 16'h5b5a;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        step(addr_gen_pkg::STEP_REL, 3'h2, 8'hfe, 16'h0000, 5'h00);
        step_valid <= 1'b0;
        repeat (10) @(posedge sys_clk);
        check({16'h0000, 16'(pc_q.size() + op_q.size())}, 32'h0000_0000);
        summarize();
    end
endmodule
